// *** hdl/ipa_top.sv ***
// Isolator position resolution, trouble alarm timing and AHB-Lite register slave.
//
// Operation
// - Both closed selections unassigned: position follows the opened inputs only.
// - Both opened selections unassigned: position follows the closed inputs only.
// - Nothing assigned: output is deasserted, meaning opened.
// - Trouble alarm blocked when both opened or both closed selections are unassigned.
// - Closed flag high exactly while resolved position is closed, failsafe included.
// - Opened flag high exactly while resolved position is opened, failsafe included.
// - Trouble-on flag high once travelling or error persists past the delay.
// - Trouble-off flag is always the complement of trouble-on.
// - Flags replicated for 48 isolators on each of the process cards.
// - Global trouble flag is the OR of all isolator trouble flags.
// - Travelling or error drives the failsafe choice: closed, opened or last valid.
// - Trouble asserts after a shared 0.0 to 60.0 s delay in 0.1 s steps.
// - Trouble stays asserted for the same delay after the condition clears.
// - Two sets: differing definite positions give error; lone travelling set yields.
`timescale 1ns/1ps

module ipa_top
    import ipa_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata,
    input  wire logic [NUM_ISO-1:0] normally_open_contact_1,
    input  wire logic [NUM_ISO-1:0] normally_open_contact_2,
    input  wire logic [NUM_ISO-1:0] normally_closed_contact_1,
    input  wire logic [NUM_ISO-1:0] normally_closed_contact_2,
    output logic [NUM_ISO-1:0]      position_closed_flag,
    output logic [NUM_ISO-1:0]      position_opened_flag,
    output logic [NUM_ISO-1:0]      persistent_trouble_on,
    output logic [NUM_ISO-1:0]      persistent_trouble_off,
    output logic                    any_trouble,
    output logic                    irq
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic ipa_pos_t decode_set(input logic opn_on, input logic cls_on);
        ipa_pos_t p;
        case ({opn_on, cls_on})
            2'h2:    p = POS_OPENED;
            2'h1:    p = POS_CLOSED;
            2'h0:    p = POS_TRAVEL;
            default: p = POS_ERROR;
        endcase
        return p;
    endfunction : decode_set

    function automatic ipa_pos_t merge_sets(input ipa_pos_t a, input ipa_pos_t b);
        ipa_pos_t p;
        if (a == POS_TRAVEL) begin
            p = b;
        end else if (b == POS_TRAVEL) begin
            p = a;
        end else if (a == b) begin
            p = a;
        end else begin
            p = POS_ERROR;
        end
        return p;
    endfunction : merge_sets

    function automatic logic indeterminate(input ipa_pos_t p);
        return (p == POS_TRAVEL) || (p == POS_ERROR);
    endfunction : indeterminate

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [9:0]          delay_ff;
    ipa_failsafe_t       failsafe_ff;
    logic [NUM_ISO-1:0]  sel_ff [NUM_GROUPS];
    logic [IRQ_BITS-1:0] irq_stat_ff;
    logic [IRQ_BITS-1:0] irq_mask_ff;
    logic                wr_pend_ff;
    logic [7:0]          wr_addr_ff;
    logic [31:0]         hrdata_ff;

    logic [NUM_ISO-1:0]  closed_ff;
    logic [NUM_ISO-1:0]  opened_ff;
    logic [NUM_ISO-1:0]  last_closed_ff;
    logic [NUM_ISO-1:0]  alarm_ff;
    logic [9:0]          cnt_ff [NUM_ISO];
    logic [31:0]         tick_cnt_ff;
    logic                tick_ff;
    logic                any_ff;

    // ------------------------------------------------------------------
    // Position resolution
    // ------------------------------------------------------------------
    ipa_pos_t           pos      [NUM_ISO];
    logic [NUM_ISO-1:0] nxt_closed;
    logic [NUM_ISO-1:0] nxt_opened;
    logic [NUM_ISO-1:0] bad;
    logic [NUM_ISO-1:0] opn_asg;
    logic [NUM_ISO-1:0] cls_asg;
    logic [NUM_ISO-1:0] opn_any;
    logic [NUM_ISO-1:0] cls_any;
    logic [NUM_ISO-1:0] set1_full;
    logic [NUM_ISO-1:0] set2_full;

    assign opn_asg   = sel_ff[GRP_OPN1] | sel_ff[GRP_OPN2];
    assign cls_asg   = sel_ff[GRP_CLS1] | sel_ff[GRP_CLS2];
    assign opn_any   = (sel_ff[GRP_OPN1] & normally_closed_contact_1)
                     | (sel_ff[GRP_OPN2] & normally_closed_contact_2);
    assign cls_any   = (sel_ff[GRP_CLS1] & normally_open_contact_1)
                     | (sel_ff[GRP_CLS2] & normally_open_contact_2);
    assign set1_full = sel_ff[GRP_OPN1] & sel_ff[GRP_CLS1];
    assign set2_full = sel_ff[GRP_OPN2] & sel_ff[GRP_CLS2];

    // Every index is one isolator; cards occupy consecutive blocks of 48.
    always_comb begin
        for (int i = 0; i < NUM_ISO; i++) begin
            if (!opn_asg[i] && !cls_asg[i]) begin
                pos[i] = POS_OPENED;
            end else if (!cls_asg[i]) begin
                pos[i] = opn_any[i] ? POS_OPENED : POS_CLOSED;
            end else if (!opn_asg[i]) begin
                pos[i] = cls_any[i] ? POS_CLOSED : POS_OPENED;
            end else if (set1_full[i] && set2_full[i]) begin
                pos[i] = merge_sets(
                    decode_set(normally_closed_contact_1[i], normally_open_contact_1[i]),
                    decode_set(normally_closed_contact_2[i], normally_open_contact_2[i]));
            end else if (set1_full[i]) begin
                pos[i] = decode_set(normally_closed_contact_1[i], normally_open_contact_1[i]);
            end else if (set2_full[i]) begin
                pos[i] = decode_set(normally_closed_contact_2[i], normally_open_contact_2[i]);
            end else begin
                // Crossed partial assignment: pool whatever is assigned on each side.
                pos[i] = decode_set(opn_any[i], cls_any[i]);
            end

            case (pos[i])
                POS_CLOSED: nxt_closed[i] = 1'b1;
                POS_OPENED: nxt_closed[i] = 1'b0;
                default: begin
                    case (failsafe_ff)
                        FS_CLOSED: nxt_closed[i] = 1'b1;
                        FS_LAST:   nxt_closed[i] = last_closed_ff[i];
                        default:   nxt_closed[i] = 1'b0;
                    endcase
                end
            endcase
            nxt_opened[i] = ~nxt_closed[i];
            bad[i] = indeterminate(pos[i]) && opn_asg[i] && cls_asg[i];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            closed_ff <= '0;
            opened_ff <= '1;
        end else begin
            closed_ff <= nxt_closed;
            opened_ff <= nxt_opened;
        end
    end

    // The last valid position is kept in flip-flops only and is lost at reset.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_closed_ff <= '0;
        end else begin
            for (int i = 0; i < NUM_ISO; i++) begin
                if (!indeterminate(pos[i])) begin
                    last_closed_ff[i] <= (pos[i] == POS_CLOSED);
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Trouble timing
    // ------------------------------------------------------------------
    logic [9:0] delay_eff;

    assign delay_eff = (delay_ff > DELAY_MAX) ? DELAY_MAX : delay_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_ff <= 32'h0;
            tick_ff     <= 1'b0;
        end else if (tick_cnt_ff >= TICK_LEN - 1) begin
            tick_cnt_ff <= 32'h0;
            tick_ff     <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h1;
            tick_ff     <= 1'b0;
        end
    end

    // One counter per isolator times any disagreement between the condition and
    // the alarm, so the same delay serves both the raise and the release.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alarm_ff <= '0;
            for (int i = 0; i < NUM_ISO; i++) begin
                cnt_ff[i] <= 10'h0;
            end
        end else begin
            for (int i = 0; i < NUM_ISO; i++) begin
                if (bad[i] == alarm_ff[i]) begin
                    cnt_ff[i] <= 10'h0;
                end else if (cnt_ff[i] >= delay_eff) begin
                    alarm_ff[i] <= bad[i];
                    cnt_ff[i]   <= 10'h0;
                end else if (tick_ff) begin
                    cnt_ff[i] <= cnt_ff[i] + 10'h1;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            any_ff <= 1'b0;
        end else begin
            any_ff <= |alarm_ff;
        end
    end

    assign position_closed_flag   = closed_ff;
    assign position_opened_flag   = opened_ff;
    assign persistent_trouble_on  = alarm_ff;
    assign persistent_trouble_off = ~alarm_ff;
    assign any_trouble            = any_ff;

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    logic        addr_phase;
    logic [7:0]  a_ofs;
    logic [31:0] rd_mux;
    logic        wr_en;

    assign addr_phase = hsel && hready && htrans[1];
    assign a_ofs      = haddr[7:0];
    assign wr_en      = wr_pend_ff;
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = hrdata_ff;

    always_comb begin
        rd_mux = 32'h0;
        case (a_ofs)
            OFS_CTRL: begin
                rd_mux[CTRL_DELAY_LSB +: 10] = delay_ff;
                rd_mux[CTRL_FS_LSB +: 2]     = failsafe_ff;
            end
            OFS_IRQ_STAT: rd_mux[IRQ_BITS-1:0] = irq_stat_ff;
            OFS_IRQ_MASK: rd_mux[IRQ_BITS-1:0] = irq_mask_ff;
            OFS_GLOBAL:   rd_mux[0] = any_ff;
            default: begin
                for (int g = 0; g < NUM_GROUPS; g++) begin
                    for (int w = 0; w < VEC_WORDS; w++) begin
                        if (a_ofs == OFS_SEL_BASE + 8'((g * VEC_WORDS + w) * 4)) begin
                            rd_mux = sel_ff[g][32*w +: 32];
                        end
                    end
                end
                for (int w = 0; w < VEC_WORDS; w++) begin
                    if (a_ofs == OFS_CLS_BASE + 8'(w * 4)) begin
                        rd_mux = closed_ff[32*w +: 32];
                    end
                    if (a_ofs == OFS_OPN_BASE + 8'(w * 4)) begin
                        rd_mux = opened_ff[32*w +: 32];
                    end
                    if (a_ofs == OFS_TRB_BASE + 8'(w * 4)) begin
                        rd_mux = alarm_ff[32*w +: 32];
                    end
                end
            end
        endcase
    end

    // Read data is captured at the address phase, so a read that directly
    // follows a write to the same register returns the value before the write.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            hrdata_ff  <= 32'h0;
        end else begin
            wr_pend_ff <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr_ff <= a_ofs;
                if (!hwrite) begin
                    hrdata_ff <= rd_mux;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            delay_ff    <= DELAY_RST;
            failsafe_ff <= FS_CLOSED;
            irq_mask_ff <= IRQ_RST;
        end else if (wr_en) begin
            if (wr_addr_ff == OFS_CTRL) begin
                delay_ff    <= hwdata[CTRL_DELAY_LSB +: 10];
                failsafe_ff <= ipa_failsafe_t'(hwdata[CTRL_FS_LSB +: 2]);
            end
            if (wr_addr_ff == OFS_IRQ_MASK) begin
                irq_mask_ff <= hwdata[IRQ_BITS-1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                sel_ff[g] <= '0;
            end
        end else if (wr_en) begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                for (int w = 0; w < VEC_WORDS; w++) begin
                    if (wr_addr_ff == OFS_SEL_BASE + 8'((g * VEC_WORDS + w) * 4)) begin
                        sel_ff[g][32*w +: 32] <= hwdata;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    logic [IRQ_BITS-1:0] irq_ev;
    logic [IRQ_BITS-1:0] irq_clr;

    assign irq_ev[IRQ_TRB_SET] = (|alarm_ff) && !any_ff;
    assign irq_ev[IRQ_TRB_CLR] = !(|alarm_ff) && any_ff;
    assign irq_ev[IRQ_POS_CHG] = |(nxt_closed ^ closed_ff);
    assign irq_clr = (wr_en && wr_addr_ff == OFS_IRQ_STAT) ? hwdata[IRQ_BITS-1:0] : IRQ_RST;

    // A new event in the clearing cycle survives the write-one-to-clear.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_ff <= IRQ_RST;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_ev;
        end
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);

endmodule : ipa_top

// *** hdl/ipa_pkg.sv ***
// Constants, types and register map of the isolator position and alarm block.
package ipa_pkg;

    // ------------------------------------------------------------------
    // Sizing
    // ------------------------------------------------------------------
    localparam int NUM_CARDS    = 2;
    localparam int ISO_PER_CARD = 48;
    localparam int NUM_ISO      = NUM_CARDS * ISO_PER_CARD;
    localparam int VEC_WORDS    = 3;
    localparam int NUM_GROUPS   = 4;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_HZ       = 20_000_000;
    localparam int          TICK_TIME_MS = 100;
    localparam int unsigned TICK_CYCLES  = (CLK_HZ / 1000) * TICK_TIME_MS;
    localparam logic [9:0]  DELAY_MAX    = 10'h258;
    localparam logic [9:0]  DELAY_RST    = 10'h064;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
    localparam logic [7:0] OFS_GLOBAL   = 8'h0C;
    localparam logic [7:0] OFS_SEL_BASE = 8'h10;
    localparam logic [7:0] OFS_CLS_BASE = 8'h40;
    localparam logic [7:0] OFS_OPN_BASE = 8'h4C;
    localparam logic [7:0] OFS_TRB_BASE = 8'h58;

    // Selection groups, in the order their words appear from OFS_SEL_BASE.
    localparam int GRP_OPN1 = 0;
    localparam int GRP_OPN2 = 1;
    localparam int GRP_CLS1 = 2;
    localparam int GRP_CLS2 = 3;

    // Control register fields.
    localparam int CTRL_DELAY_LSB = 0;
    localparam int CTRL_FS_LSB    = 16;

    // Interrupt status bits.
    localparam int IRQ_TRB_SET = 0;
    localparam int IRQ_TRB_CLR = 1;
    localparam int IRQ_POS_CHG = 2;
    localparam int IRQ_BITS    = 3;

    localparam logic [IRQ_BITS-1:0] IRQ_RST = 3'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        POS_OPENED = 2'h0,
        POS_CLOSED = 2'h1,
        POS_ERROR  = 2'h3,
        POS_TRAVEL = 2'h2
    } ipa_pos_t;

    typedef enum logic [1:0] {
        FS_CLOSED = 2'h0,
        FS_OPENED = 2'h1,
        FS_LAST   = 2'h2
    } ipa_failsafe_t;

endpackage : ipa_pkg

// *** tb/ipa_chk.sv ***
// Concurrent checks on the ports of the isolator position and alarm block.
`timescale 1ns/1ps

module ipa_chk
    import ipa_pkg::*;
(
    input wire logic               hclk,
    input wire logic               hresetn,
    input wire logic               hsel,
    input wire logic [31:0]        haddr,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic [31:0]        hwdata,
    input wire logic               hready,
    input wire logic               hreadyout,
    input wire logic               hresp,
    input wire logic [NUM_ISO-1:0] position_closed_flag,
    input wire logic [NUM_ISO-1:0] position_opened_flag,
    input wire logic [NUM_ISO-1:0] persistent_trouble_on,
    input wire logic [NUM_ISO-1:0] persistent_trouble_off,
    input wire logic               any_trouble,
    input wire logic               irq
);
    // ------------------------------------------------------------------
    // Mask shadow
    // ------------------------------------------------------------------
    // The mask is rebuilt from bus writes so irq can be judged from ports alone.
    logic       wr_ph_ff;
    logic [7:0] wr_adr_ff;
    logic [2:0] msk_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph_ff  <= 1'b0;
            wr_adr_ff <= 8'h00;
        end else if (hready) begin
            wr_ph_ff  <= hsel & htrans[1] & hwrite;
            wr_adr_ff <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            msk_ff <= 3'h0;
        end else if (wr_ph_ff && wr_adr_ff == OFS_IRQ_MASK) begin
            msk_ff <= hwdata[2:0];
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_off; persistent_trouble_off == ~persistent_trouble_on; endproperty
    a_off: assert property (p_off) else $error("trouble off not inverse of on");
    property p_pos; position_opened_flag == ~position_closed_flag; endproperty
    a_pos: assert property (p_pos) else $error("opened flag not inverse of closed");
    property p_rst;
        $rose(hresetn) |-> (position_closed_flag == '0 && persistent_trouble_on == '0) [*3];
    endproperty
    a_rst: assert property (p_rst) else $error("flags not opened after reset");
    property p_glob; any_trouble == |$past(persistent_trouble_on); endproperty
    a_glob: assert property (p_glob) else $error("global trouble not the OR");
    property p_lat; $rose(|persistent_trouble_on) |-> ##1 any_trouble; endproperty
    a_lat: assert property (p_lat) else $error("global trouble late");
    property p_bus; hreadyout && !hresp; endproperty
    a_bus: assert property (p_bus) else $error("bus slave not ready or not okay");
    property p_irqm; irq |-> msk_ff != 3'h0; endproperty
    a_irqm: assert property (p_irqm) else $error("interrupt while all masked");
    property p_irqr; $rose(any_trouble) && msk_ff[0] |-> irq; endproperty
    a_irqr: assert property (p_irqr) else $error("trouble raised without interrupt");

    c_trb: cover property ($rose(any_trouble));
    c_clr: cover property ($fell(any_trouble));
    c_irq: cover property ($rose(irq));
endmodule : ipa_chk

bind ipa_top ipa_chk i_ipa_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hready, .hreadyout, .hresp, .position_closed_flag, .position_opened_flag,
    .persistent_trouble_on, .persistent_trouble_off, .any_trouble, .irq);

// *** tb/ipa_contacts.sv ***
// Behavioural model of the remote contact-status units feeding the block.
`timescale 1ns/1ps

module ipa_contacts
    import ipa_pkg::*;
(
    input wire logic [0:0]           hclk,
    input wire logic [1:0]           lag,
    input wire logic [4*NUM_ISO-1:0] want,
    output logic [4*NUM_ISO-1:0]     cont
);
    // Each stage is one cycle of report latency; a slow unit answers late.
    logic [4*NUM_ISO-1:0] pipe_ff [4];

    always_ff @(posedge hclk) begin
        pipe_ff[0] <= want;
        for (int i = 1; i < 4; i++) begin
            pipe_ff[i] <= pipe_ff[i-1];
        end
    end

    assign cont = pipe_ff[lag];
endmodule : ipa_contacts

// *** tb/tb_top.sv ***
// Self-checking bench for the isolator position and alarm block.
`timescale 1ns/1ps

module tb_top
    import ipa_pkg::*;
;
    localparam int TL = 10;

    logic                 hclk;
    logic                 hresetn;
    logic                 hsel;
    logic [31:0]          haddr;
    logic [1:0]           htrans;
    logic                 hwrite;
    logic [2:0]           hsize;
    logic [31:0]          hwdata;
    logic                 hreadyout;
    logic                 hresp;
    logic [31:0]          hrdata;
    logic [NUM_ISO-1:0]   trb_on;
    logic                 any_trouble;
    logic                 irq;
    logic [1:0]           lag;
    logic [4*NUM_ISO-1:0] want;
    logic [4*NUM_ISO-1:0] cont;
    logic                 rd_ph;
    logic [31:0]          seed;
    logic [NUM_ISO-1:0]   r;
    logic [NUM_ISO-1:0]   e;
    logic [NUM_ISO-1:0]   t;
    logic [31:0]          exp_q[$];
    int                   error_cnt;
    int                   check_count;
    int                   n;

    ipa_top #(.TICK_LEN(TL)) i_ipa_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .normally_open_contact_1(cont[0 +: NUM_ISO]),
        .normally_open_contact_2(cont[NUM_ISO +: NUM_ISO]),
        .normally_closed_contact_1(cont[2*NUM_ISO +: NUM_ISO]),
        .normally_closed_contact_2(cont[3*NUM_ISO +: NUM_ISO]),
        .position_closed_flag(), .position_opened_flag(), .persistent_trouble_on(trb_on),
        .persistent_trouble_off(), .any_trouble(any_trouble), .irq(irq));

    ipa_contacts i_ipa_contacts (.hclk(hclk), .lag(lag), .want(want), .cont(cont));

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        check_count++;
        if (seen !== expv) begin
            error_cnt++;
            $display("Error %0t: saw %h expected %h", $time, seen, expv);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    task automatic hwait();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 64);
        if (hreadyout !== 1'b1) begin
            error_cnt++;
            wrap_up();
        end
    endtask : hwait

    // One single word transfer; a read notes its expected data for the monitor.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] ev);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        hwait();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph  <= ~wr;
        if (!wr) exp_q.push_back(ev);
        hwait();
        rd_ph  <= 1'b0;
    endtask : bus

    always @(posedge hclk) begin
        if (rd_ph === 1'b1 && hreadyout === 1'b1) begin
            chk(hrdata, exp_q.pop_front());
        end
    end

    task automatic sel(input logic [3:0] g);
        for (int i = 0; i < 12; i++) begin
            bus(1'b1, OFS_SEL_BASE + 8'(4 * i), {32{g[i/3]}}, 32'h0);
        end
    endtask : sel

    task automatic setc(input logic [NUM_ISO-1:0] no1, no2, nc1, nc2);
        want <= {nc2, nc1, no2, no1};
        repeat (8) @(posedge hclk);
    endtask : setc

    task automatic flags(input logic [NUM_ISO-1:0] c);
        for (int w = 0; w < 3; w++) begin
            bus(1'b0, OFS_CLS_BASE + 8'(4 * w), 32'h0, c[32*w +: 32]);
            bus(1'b0, OFS_OPN_BASE + 8'(4 * w), 32'h0, ~c[32*w +: 32]);
        end
    endtask : flags

    task automatic twait(input logic lvl, input int lo, input int hi);
        n = 0;
        while (trb_on[NUM_ISO-1] !== lvl && n < hi + 8) begin
            @(posedge hclk);
            n++;
        end
        chk({31'h0, n >= lo && n <= hi}, 32'h1);
        if (trb_on[NUM_ISO-1] !== lvl) begin
            wrap_up();
        end
    endtask : twait

    initial begin
        repeat (100000) @(posedge hclk);
        error_cnt++;
        wrap_up();
    end

    initial begin
        {hresetn, hsel, hwrite, rd_ph, lag} = '0;
        {haddr, htrans, hwdata, want} = '0;
        hsize = 3'h2;
        seed = 32'h0000002F;
        error_cnt = 0;
        check_count = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, OFS_CTRL, 32'h0, 32'h00000064);
        bus(1'b0, OFS_IRQ_MASK, 32'h0, 32'h0);
        bus(1'b0, 8'h80, 32'h0, 32'h0);
        flags('0);
        r = {rnd(), rnd(), rnd()};
        t = {rnd(), rnd(), rnd()};
        r[NUM_ISO-1] = 1'b1;
        sel(4'h5);
        setc(r, '0, ~r, '0);
        flags(r);
        sel(4'h3);
        setc(t, t, ~r, '0);
        flags(r);
        sel(4'hC);
        setc(r, '0, t, ~t);
        flags(r);
        sel(4'h0);
        setc(t, r, ~t, r);
        flags('0);
        // Slow units here: every contact report arrives four cycles late.
        sel(4'hF);
        lag <= 2'h3;
        e = {rnd(), rnd(), rnd()} & ~t;
        setc(r, (r & ~t) ^ e, ~r, (~r & ~t) ^ e);
        flags(r | e);
        lag <= 2'h0;
        sel(4'h5);
        r[0] = 1'b1;
        setc(r, '0, ~r, '0);
        setc(r, '0, ~r | 96'h1, '0);
        for (int f = 0; f < 4; f++) begin
            bus(1'b1, OFS_CTRL, {14'h0, 2'(f), 16'h0064}, 32'h0);
            repeat (2) @(posedge hclk);
            bus(1'b0, OFS_CLS_BASE, 32'h0, {r[31:1], f == 0 || f == 2});
        end
        setc(r, '0, ~r, '0);
        bus(1'b1, OFS_CTRL, 32'h00010004, 32'h0);
        bus(1'b1, OFS_IRQ_MASK, 32'h2, 32'h0);
        bus(1'b1, OFS_IRQ_STAT, 32'h7, 32'h0);
        e = '0;
        e[NUM_ISO-1] = 1'b1;
        // A short fault must not leave a partial count behind for the next one.
        want <= {{NUM_ISO{1'b0}}, ~r | e, {NUM_ISO{1'b0}}, r | e};
        repeat (25) @(posedge hclk);
        setc(r, '0, ~r, '0);
        chk({31'h0, trb_on[NUM_ISO-1]}, 32'h0);
        want <= {{NUM_ISO{1'b0}}, ~r | e, {NUM_ISO{1'b0}}, r | e};
        twait(1'b1, 3 * TL, 4 * TL + 6);
        flags(r & ~e);
        bus(1'b0, OFS_GLOBAL, 32'h0, 32'h1);
        bus(1'b0, OFS_TRB_BASE + 8'h08, 32'h0, 32'h80000000);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, OFS_IRQ_MASK, 32'h1, 32'h0);
        @(negedge hclk);
        chk({31'h0, irq}, 32'h1);
        want <= {{NUM_ISO{1'b0}}, ~r, {NUM_ISO{1'b0}}, r};
        twait(1'b0, 3 * TL, 4 * TL + 6);
        bus(1'b0, OFS_IRQ_STAT, 32'h0, 32'h7);
        bus(1'b1, OFS_IRQ_STAT, 32'h7, 32'h0);
        bus(1'b0, OFS_IRQ_STAT, 32'h0, 32'h0);
        @(negedge hclk);
        chk({31'h0, irq}, 32'h0);
        // Zero delay is the boundary: trouble follows the condition at once.
        bus(1'b1, OFS_CTRL, 32'h0, 32'h0);
        want <= {{NUM_ISO{1'b0}}, ~r | e, {NUM_ISO{1'b0}}, r | e};
        twait(1'b1, 0, 4);
        sel(4'h3);
        repeat (8) @(posedge hclk);
        flags(r & ~e);
        bus(1'b0, OFS_TRB_BASE + 8'h08, 32'h0, 32'h0);
        wrap_up();
    end
endmodule : tb_top
